// ===== rtl/srs_response_select.sv
// top: response slot selection, command feedforward and update watch
`timescale 1ns/1ps
`default_nettype none
module srs_response_select #(
    parameter int unsigned DATA_W = srs_pkg::DATA_W
) (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // settings
    input  wire logic [15:0]                 warn_threshold,
    input  wire logic [15:0]                 prot_threshold,
    input  wire logic [15:0]                 monitor_sel [srs_pkg::NUM_SEL],
    input  wire logic [15:0]                 cmd_setting,
    input  wire logic [15:0]                 cmd_setting_two,
    input  wire logic [15:0]                 cmd_setting_three,
    input  wire logic                        speed_unit,
    input  wire logic                        mode_32byte,
    // cycle from link
    input  wire logic                        cycle_tick,
    input  wire logic                        update_ok,
    input  wire logic [3:0]                  noncyclic_cmd,
    input  wire logic [3:0]                  sub_cmd,
    input  wire logic                        noncyclic_uses_slot3,
    input  wire logic [DATA_W-1:0]           command_slot_three,
    input  wire logic [DATA_W-1:0]           sub_command_slot_two,
    input  wire logic [DATA_W-1:0]           sub_command_slot_three,
    // monitor sources, indexed by type code
    input  wire logic [DATA_W-1:0]           monitor_value [srs_pkg::NUM_CODES],
    input  wire logic [DATA_W-1:0]           noncyclic_reply_two,
    input  wire logic [DATA_W-1:0]           noncyclic_reply_three,
    input  wire logic [DATA_W-1:0]           sub_reply_one,
    // responses
    output srs_pkg::srs_slots_t              response,
    output srs_pkg::srs_slots_t              sub_response,
    output srs_pkg::srs_ff_t                 ff_main,
    output srs_pkg::srs_ff_t                 ff_sub_two,
    output srs_pkg::srs_ff_t                 ff_sub_three,
    output logic                             speed_in_cmd_units,
    // supervision
    output logic                             refresh_count_warning,
    output logic [7:0]                       warning_code,
    output logic                             update_alarm,
    output logic [7:0]                       alarm_main,
    output logic [3:0]                       alarm_sub
);
    ////////////////////////////////////////////////////////////////////////
    // type code per select and default substitution
    logic [7:0] code [srs_pkg::NUM_SEL];
    logic [7:0] eff  [srs_pkg::NUM_SEL];
    logic       zero [srs_pkg::NUM_SEL];

    genvar gi;
    generate
        for (gi = 0; gi < srs_pkg::NUM_SEL; gi++) begin : g_sel
            assign code[gi] = monitor_sel[gi][7:0];
            assign zero[gi] = (code[gi] == srs_pkg::CODE_DEFAULT);
        end
    endgenerate

    assign eff[0] = zero[0] ? srs_pkg::CODE_POSITION : code[0];
    assign eff[1] = zero[1] ? srs_pkg::CODE_SPEED    : code[1];
    assign eff[2] = zero[2] ? srs_pkg::CODE_TORQUE   : code[2];
    assign eff[3] = code[3];
    assign eff[4] = code[4];
    assign eff[5] = code[5];

    wire logic nc_idle  = (noncyclic_cmd == 4'h0);
    wire logic sub_idle = (sub_cmd == 4'h0);

    ////////////////////////////////////////////////////////////////////////
    // slot data
    wire logic [DATA_W-1:0] r1_d = monitor_value[eff[0]];
    wire logic [DATA_W-1:0] r2_d = nc_idle ? monitor_value[eff[1]] : noncyclic_reply_two;
    wire logic [DATA_W-1:0] r3_d = nc_idle ? monitor_value[eff[2]] : noncyclic_reply_three;
    wire logic [DATA_W-1:0] s1_sel = zero[3] ? '0 : monitor_value[eff[3]];
    wire logic [DATA_W-1:0] s1_d = !mode_32byte ? '0 : (sub_idle ? s1_sel : sub_reply_one);
    wire logic [DATA_W-1:0] s2_d = (!mode_32byte || zero[4]) ? '0 : monitor_value[eff[4]];
    wire logic [DATA_W-1:0] s3_d = (!mode_32byte || zero[5]) ? '0 : monitor_value[eff[5]];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            response     <= '0;
            sub_response <= '0;
        end else if (cycle_tick) begin
            response     <= '{slot_one: r1_d, slot_two: r2_d, slot_three: r3_d};
            sub_response <= '{slot_one: s1_d, slot_two: s2_d, slot_three: s3_d};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command feedforward
    srs_pkg::srs_ff_t ff_m_c;
    srs_pkg::srs_ff_t ff_2_c;
    srs_pkg::srs_ff_t ff_3_c;

    srs_ff_decode u_ff_main (
        .setting   (cmd_setting),
        .slot_data (command_slot_three),
        .slot_busy (noncyclic_uses_slot3),
        .ff        (ff_m_c)
    );
    srs_ff_decode u_ff_two (
        .setting   (cmd_setting_two),
        .slot_data (sub_command_slot_two),
        .slot_busy (!mode_32byte),
        .ff        (ff_2_c)
    );
    srs_ff_decode u_ff_three (
        .setting   (cmd_setting_three),
        .slot_data (sub_command_slot_three),
        .slot_busy (!mode_32byte),
        .ff        (ff_3_c)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ff_main      <= '0;
            ff_sub_two   <= '0;
            ff_sub_three <= '0;
        end else if (cycle_tick) begin
            ff_main      <= ff_m_c;
            ff_sub_two   <= ff_2_c;
            ff_sub_three <= ff_3_c;
        end
    end

    // speed data units pass through as a flag to the velocity path
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            speed_in_cmd_units <= 1'b0;
        end else begin
            speed_in_cmd_units <= speed_unit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // update counter supervision
    wire logic [15:0] prot_limit = (prot_threshold > srs_pkg::THRESH_MAX) ?
                                   srs_pkg::THRESH_MAX : prot_threshold;

    srs_update_watch u_warn (
        .clock      (clock),
        .rst_n      (rst_n),
        .cycle_tick (cycle_tick),
        .update_ok  (update_ok),
        .threshold  (warn_threshold),
        .tripped    (refresh_count_warning),
        .fail_count ()
    );
    srs_update_watch u_prot (
        .clock      (clock),
        .rst_n      (rst_n),
        .cycle_tick (cycle_tick),
        .update_ok  (update_ok),
        .threshold  (prot_limit),
        .tripped    (update_alarm),
        .fail_count ()
    );

    assign warning_code = refresh_count_warning ? srs_pkg::WARN_CODE : 8'h00;
    assign alarm_main   = update_alarm ? srs_pkg::ALARM_MAIN : 8'h00;
    assign alarm_sub    = update_alarm ? srs_pkg::ALARM_SUB : 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_slot_one_pos: assert property (@(posedge clock) disable iff (!rst_n)
        cycle_tick && zero[0]
        |=> response.slot_one == $past(monitor_value[srs_pkg::CODE_POSITION]))
        else $error("slot one not position on zero select");
    a_slot_two_sel: assert property (@(posedge clock) disable iff (!rst_n)
        cycle_tick && nc_idle |=> response.slot_two == $past(monitor_value[eff[1]]))
        else $error("slot two wrong monitor");
    a_slot_three_trq: assert property (@(posedge clock) disable iff (!rst_n)
        cycle_tick && nc_idle && zero[2]
        |=> response.slot_three == $past(monitor_value[srs_pkg::CODE_TORQUE]))
        else $error("slot three not torque on zero select");
    a_sub_one_zero: assert property (@(posedge clock) disable iff (!rst_n)
        cycle_tick && mode_32byte && sub_idle && zero[3] |=> sub_response.slot_one == '0)
        else $error("sub slot one not zero");
    a_sub_two_zero: assert property (@(posedge clock) disable iff (!rst_n)
        cycle_tick && zero[4] |=> sub_response.slot_two == '0)
        else $error("sub slot two not zero");
    a_ff_busy_slot: assert property (@(posedge clock) disable iff (!rst_n)
        cycle_tick && noncyclic_uses_slot3 |=> !ff_main.velocity_valid && !ff_main.torque_valid)
        else $error("feedforward taken from busy slot");
    a_ff_torque_mode: assert property (@(posedge clock) disable iff (!rst_n)
        cycle_tick && !noncyclic_uses_slot3 && cmd_setting == 16'h0002
        |=> ff_main.torque_valid && ff_main.torque_ff == $past(command_slot_three))
        else $error("torque feedforward missing");
    a_ff_sub_vel: assert property (@(posedge clock) disable iff (!rst_n)
        cycle_tick && mode_32byte && cmd_setting_two == 16'h0001 |=> ff_sub_two.velocity_valid)
        else $error("sub velocity feedforward missing");
    a_prot_disable: assert property (@(posedge clock) disable iff (!rst_n)
        (prot_threshold <= 16'h0001) [*2] |-> !update_alarm)
        else $error("alarm while protection disabled");
    a_unit_follow: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 speed_in_cmd_units == $past(speed_unit))
        else $error("speed unit flag stale");
    a_code_low_bits: assert property (@(posedge clock) disable iff (!rst_n)
        cycle_tick && !zero[0] |=> response.slot_one == $past(monitor_value[monitor_sel[0][7:0]]))
        else $error("type code not low byte");

    c_warning: cover property (@(posedge clock) disable iff (!rst_n) $rose(refresh_count_warning));
    c_alarm: cover property (@(posedge clock) disable iff (!rst_n) $rose(update_alarm));
    c_sub_mode: cover property (@(posedge clock) disable iff (!rst_n) cycle_tick && mode_32byte);
    c_ff_vel: cover property (@(posedge clock) disable iff (!rst_n) ff_main.velocity_valid);
endmodule
`default_nettype wire

// ===== rtl/srs_pkg.sv
// package: constants and carrier types for the response select block
// What this block does
// - warn when failed updates exceed warning threshold
// - warning threshold zero or one disables warning
// - alarm when failed updates exceed protection threshold
// - protection threshold zero or one disables; max 32767
// - response slot one: select 1, zero gives position
// - slot two: select 2 when non-cyclic zero
// - slot three: select 3 when non-cyclic zero, zero gives torque
// - 32-byte sub slot one: select 4 when sub command zero, zero-zero
// - sub slots two, three: selects 5, 6
// - command slot three: unused, velocity, torque feedforward
// - ignore feedforward when command uses slot three
// - sub command slots two, three same encoding
// - speed unit: 0 rpm, 1 command units/s
package srs_pkg;
    localparam int unsigned DATA_W        = 32;
    localparam int unsigned CODE_W        = 8;
    localparam int unsigned SET_W         = 16;
    localparam logic [15:0] THRESH_MAX    = 16'h7fff;
    localparam logic [15:0] THRESH_OFF1   = 16'h0001;
    localparam logic [7:0]  WARN_CODE     = 8'hc2;
    localparam logic [7:0]  ALARM_MAIN    = 8'h56;
    localparam logic [3:0]  ALARM_SUB     = 4'h2;
    localparam logic [7:0]  CODE_DEFAULT  = 8'h00;
    localparam logic [7:0]  CODE_POSITION = 8'h01;
    localparam logic [7:0]  CODE_SPEED    = 8'h02;
    localparam logic [7:0]  CODE_TORQUE   = 8'h03;
    localparam int unsigned NUM_SEL       = 6;
    localparam int unsigned NUM_CODES     = 256;

    typedef enum logic [1:0] {
        SRS_FF_UNUSED,
        SRS_FF_VELOCITY,
        SRS_FF_TORQUE,
        SRS_FF_RSVD
    } srs_ff_mode_t;

    typedef struct packed {
        logic [DATA_W-1:0] velocity_ff;
        logic [DATA_W-1:0] torque_ff;
        logic              velocity_valid;
        logic              torque_valid;
    } srs_ff_t;

    typedef struct packed {
        logic [DATA_W-1:0] slot_one;
        logic [DATA_W-1:0] slot_two;
        logic [DATA_W-1:0] slot_three;
    } srs_slots_t;
endpackage

// ===== rtl/srs_ff_decode.sv
// feedforward decode for one command data slot
`timescale 1ns/1ps
`default_nettype none
module srs_ff_decode (
    // setting and data
    input  wire logic [srs_pkg::SET_W-1:0]  setting,
    input  wire logic [srs_pkg::DATA_W-1:0] slot_data,
    input  wire logic                       slot_busy,
    // decoded
    output srs_pkg::srs_ff_t                ff
);
    wire logic [1:0] mode = setting[1:0];
    wire logic       legal = (setting[srs_pkg::SET_W-1:2] == '0) && !slot_busy;
    wire logic       is_vel = legal && (mode == 2'(srs_pkg::SRS_FF_VELOCITY));
    wire logic       is_trq = legal && (mode == 2'(srs_pkg::SRS_FF_TORQUE));

    assign ff.velocity_valid = is_vel;
    assign ff.torque_valid   = is_trq;
    assign ff.velocity_ff    = is_vel ? slot_data : '0;
    assign ff.torque_ff      = is_trq ? slot_data : '0;
endmodule
`default_nettype wire

// ===== rtl/srs_update_watch.sv
// update counter supervision: warning or alarm on failed updates
`timescale 1ns/1ps
`default_nettype none
module srs_update_watch (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // cycle events
    input  wire logic        cycle_tick,
    input  wire logic        update_ok,
    // thresholds
    input  wire logic [15:0] threshold,
    // result
    output logic             tripped,
    output logic [15:0]      fail_count
);
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic        trip_q;
    wire  logic  enabled = (threshold > srs_pkg::THRESH_OFF1);
    wire  logic  sat     = (count_q == srs_pkg::THRESH_MAX);

    always_comb begin
        count_d = count_q;
        if (cycle_tick) begin
            if (update_ok) begin
                count_d = '0;
            end else if (!sat) begin
                count_d = count_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_q <= '0;
            trip_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            trip_q  <= enabled && (count_d > threshold);
        end
    end

    assign tripped    = trip_q;
    assign fail_count = count_q;

    a_trip_cause: assert property (@(posedge clock) disable iff (!rst_n)
        tripped |-> $past(enabled) && (fail_count > $past(threshold)))
        else $error("trip without counted failures");
    a_trip_disable: assert property (@(posedge clock) disable iff (!rst_n)
        ($past(threshold) <= 16'h0001) |-> !tripped)
        else $error("trip while disabled");
endmodule
`default_nettype wire

// ===== test/srs_master_model.sv
// master controller model: link cycle ticks, update flags and command data
`timescale 1ns/1ps
`default_nettype none
module srs_master_model (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // bench control
    input  wire logic        run,
    input  wire logic [2:0]  gap,
    input  wire logic        fail_all,
    // link cycle
    output logic             cycle_tick,
    output logic             update_ok,
    output logic [3:0]       noncyclic_cmd,
    output logic [3:0]       sub_cmd,
    output logic             noncyclic_uses_slot3,
    output logic [31:0]      command_slot_three,
    output logic [31:0]      sub_command_slot_two,
    output logic [31:0]      sub_command_slot_three
);
    logic [2:0] wait_q;
    logic [3:0] nc;
    // data lines change every cycle, not only on ticks
    always @(posedge clock) begin
        nc = ($urandom % 2) ? 4'($urandom) : 4'h0;
        noncyclic_cmd <= nc;
        noncyclic_uses_slot3 <= (nc != 4'h0) && ($urandom % 2);
        sub_cmd <= ($urandom % 2) ? 4'($urandom) : 4'h0;
        command_slot_three <= $urandom;
        sub_command_slot_two <= $urandom;
        sub_command_slot_three <= $urandom;
        update_ok <= !fail_all && ($urandom % 4 != 0);
        if (!rst_n || !run || wait_q != 3'h0) begin
            cycle_tick <= 1'b0;
            wait_q <= (!rst_n || !run) ? 3'h0 : wait_q - 3'h1;
        end else begin
            cycle_tick <= 1'b1;
            wait_q <= gap;
        end
    end
endmodule
`default_nettype wire

// ===== test/srs_response_select_tb.sv
// self-checking bench for the response select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module srs_response_select_tb;
    logic               clock, rst_n, speed_unit, mode_32byte, run, fail_all, b0, sb;
    logic [2:0]         gap;
    logic [15:0]        warn_threshold, prot_threshold, cmd_setting, cmd_setting_two;
    logic [15:0]        cmd_setting_three, m0, m1, m2, pt;
    logic [15:0]        monitor_sel [srs_pkg::NUM_SEL];
    logic [31:0]        monitor_value [srs_pkg::NUM_CODES];
    logic [31:0]        noncyclic_reply_two, noncyclic_reply_three, sub_reply_one, d0, d1, d2;
    wire logic          cycle_tick, update_ok, noncyclic_uses_slot3;
    wire logic [3:0]    noncyclic_cmd, sub_cmd;
    wire logic [31:0]   command_slot_three, sub_command_slot_two, sub_command_slot_three;
    srs_pkg::srs_slots_t response, sub_response, e_r, e_s;
    srs_pkg::srs_ff_t   ff_main, ff_sub_two, ff_sub_three;
    logic               speed_in_cmd_units, refresh_count_warning, update_alarm, exp_w, exp_a;
    logic [7:0]         warning_code, alarm_main;
    logic [3:0]         alarm_sub;
    int                 err_count = 0, cmp_count = 0, fail_cnt = 0;

    srs_master_model u_master (.clock(clock), .rst_n(rst_n), .run(run), .gap(gap),
        .fail_all(fail_all), .cycle_tick(cycle_tick), .update_ok(update_ok),
        .noncyclic_cmd(noncyclic_cmd), .sub_cmd(sub_cmd),
        .noncyclic_uses_slot3(noncyclic_uses_slot3), .command_slot_three(command_slot_three),
        .sub_command_slot_two(sub_command_slot_two),
        .sub_command_slot_three(sub_command_slot_three));
    srs_response_select u_dut (.clock(clock), .rst_n(rst_n), .warn_threshold(warn_threshold),
        .prot_threshold(prot_threshold), .monitor_sel(monitor_sel), .cmd_setting(cmd_setting),
        .cmd_setting_two(cmd_setting_two), .cmd_setting_three(cmd_setting_three),
        .speed_unit(speed_unit), .mode_32byte(mode_32byte), .cycle_tick(cycle_tick),
        .update_ok(update_ok), .noncyclic_cmd(noncyclic_cmd), .sub_cmd(sub_cmd),
        .noncyclic_uses_slot3(noncyclic_uses_slot3), .command_slot_three(command_slot_three),
        .sub_command_slot_two(sub_command_slot_two),
        .sub_command_slot_three(sub_command_slot_three), .monitor_value(monitor_value),
        .noncyclic_reply_two(noncyclic_reply_two), .noncyclic_reply_three(noncyclic_reply_three),
        .sub_reply_one(sub_reply_one), .response(response), .sub_response(sub_response),
        .ff_main(ff_main), .ff_sub_two(ff_sub_two), .ff_sub_three(ff_sub_three),
        .speed_in_cmd_units(speed_in_cmd_units), .refresh_count_warning(refresh_count_warning),
        .warning_code(warning_code), .update_alarm(update_alarm), .alarm_main(alarm_main),
        .alarm_sub(alarm_sub));

    always #5 clock = ~clock;

    function automatic logic [31:0] pick(logic [15:0] sel, logic [7:0] dflt, logic zero_out);
        if (sel[7:0] == 8'h00) return zero_out ? 32'h0 : monitor_value[dflt];
        return monitor_value[sel[7:0]];
    endfunction

    task automatic chk_ff(string nm, srs_pkg::srs_ff_t got, logic [15:0] m, logic [31:0] d,
                          logic en);
        `CHK(nm, en && m == 16'h1, got.velocity_valid)
        `CHK(nm, en && m == 16'h2, got.torque_valid)
        `CHK(nm, (en && m == 16'h1) ? d : 32'h0, got.velocity_ff)
        `CHK(nm, (en && m == 16'h2) ? d : 32'h0, got.torque_ff)
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // reference model, warning and alarm checked only when gap is two or more, the rest at every taken cycle
    always @(posedge clock) begin
        if (!rst_n) begin
            fail_cnt = 0;
        end else if (cycle_tick) begin
            e_r.slot_one = pick(monitor_sel[0], srs_pkg::CODE_POSITION, 1'b0);
            e_r.slot_two = (noncyclic_cmd == 4'h0) ?
                pick(monitor_sel[1], srs_pkg::CODE_SPEED, 1'b0) : noncyclic_reply_two;
            e_r.slot_three = (noncyclic_cmd == 4'h0) ?
                pick(monitor_sel[2], srs_pkg::CODE_TORQUE, 1'b0) : noncyclic_reply_three;
            e_s = '0;
            if (mode_32byte) begin
                e_s.slot_one = (sub_cmd == 4'h0) ?
                    pick(monitor_sel[3], 8'h00, 1'b1) : sub_reply_one;
                e_s.slot_two = pick(monitor_sel[4], 8'h00, 1'b1);
                e_s.slot_three = pick(monitor_sel[5], 8'h00, 1'b1);
            end
            fail_cnt = update_ok ? 0 : (fail_cnt < 32767 ? fail_cnt + 1 : fail_cnt);
            {m0, m1, m2, d0, d1, d2} = {cmd_setting, cmd_setting_two, cmd_setting_three,
                command_slot_three, sub_command_slot_two, sub_command_slot_three};
            {b0, sb} = {noncyclic_uses_slot3, mode_32byte};
            @(negedge clock);
            `CHK("slot one", e_r.slot_one, response.slot_one)
            `CHK("slot two", e_r.slot_two, response.slot_two)
            `CHK("slot three", e_r.slot_three, response.slot_three)
            `CHK("sub slot one", e_s.slot_one, sub_response.slot_one)
            `CHK("sub slot two", e_s.slot_two, sub_response.slot_two)
            `CHK("sub slot three", e_s.slot_three, sub_response.slot_three)
            `CHK("speed unit", speed_unit, speed_in_cmd_units)
            chk_ff("ff main", ff_main, m0, d0, !b0);
            chk_ff("ff sub two", ff_sub_two, m1, d1, sb);
            chk_ff("ff sub three", ff_sub_three, m2, d2, sb);
            if (gap >= 3'h2) begin
                @(negedge clock);
                pt = (prot_threshold > 16'h7fff) ? 16'h7fff : prot_threshold;
                exp_w = warn_threshold > 16'h1 && fail_cnt > warn_threshold;
                exp_a = pt > 16'h1 && fail_cnt > pt;
                `CHK("warning", exp_w, refresh_count_warning)
                `CHK("warning code", exp_w ? srs_pkg::WARN_CODE : 8'h00, warning_code)
                `CHK("alarm", exp_a, update_alarm)
                `CHK("alarm code", exp_a ? 12'h562 : 12'h000, {alarm_main, alarm_sub})
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {clock, rst_n, run, fail_all, gap, speed_unit, mode_32byte} = '0;
        {warn_threshold, prot_threshold, cmd_setting, cmd_setting_two, cmd_setting_three} = '0;
        {noncyclic_reply_two, noncyclic_reply_three, sub_reply_one} = '0;
        foreach (monitor_sel[i]) monitor_sel[i] = 16'h0;
        foreach (monitor_value[i]) monitor_value[i] = 32'h0;
        void'($urandom(32'h8f1a));
        repeat (12) @(posedge clock);
        @(negedge clock);
        `CHK("reset outputs", '0, {response, sub_response, refresh_count_warning, update_alarm})
        @(posedge clock);
        rst_n <= 1'b1;
        for (int k = 0; k < 40; k++) begin
            run <= 1'b0;
            repeat (4) @(posedge clock);
            foreach (monitor_sel[i]) monitor_sel[i] <= ($urandom % 3 == 0) ?
                (16'($urandom) & 16'hff00) : 16'($urandom);
            foreach (monitor_value[i]) monitor_value[i] <= $urandom;
            {cmd_setting, cmd_setting_two, cmd_setting_three} <= {16'($urandom % 4),
                16'($urandom % 4), 16'($urandom % 4)};
            warn_threshold <= 16'($urandom % 5);
            prot_threshold <= (k % 8 == 7) ? 16'hffff : 16'($urandom % 6);
            {noncyclic_reply_two, noncyclic_reply_three, sub_reply_one} <=
                {$urandom, $urandom, $urandom};
            {speed_unit, mode_32byte, fail_all} <= 3'($urandom);
            gap <= 3'($urandom % 4);
            repeat (2) @(posedge clock);
            run <= 1'b1;
            repeat (24) @(posedge clock);
        end
        run <= 1'b0;
        repeat (6) @(posedge clock);
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
